// *** verilog/ftx_coder.sv ***
`timescale 1ns/10ps
`default_nettype none

// Operation
// RL1: Data nibble maps to fixed 5-bit code-group
// RL2: Frame start sends J then K
// RL3: Later preamble and data nibbles encoded
// RL4: Enable drop sends T then R
// RL5: Idle code-groups until enable returns
// RL6: Error, no enable, nibble 1 sends LPI
// RL7: Control code-group in data flagged invalid
// RL8: 11-bit LFSR XORed with serial stream
// RL9: Scrambler can be bypassed
// RL10: Line always NRZI encoded, no bypass
// RL11: Five line bits per accepted nibble
// RL12: Sequencing per standard transmit state machine
// RL13: Polynomial x^11+x^9+1, seed never zero
module ftx_coder
   import ftx_pkg::*;
#(
   parameter int BIT_DIV    = `FTX_BIT_DIV,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire logic                  tx_valid,
   output logic                       tx_ready,
   input  wire logic                  tx_en,
   input  wire logic                  tx_er,
   input  wire logic [`FTX_NIB_W-1:0] txd,
   input  wire logic                  scr_bypass,
   output logic                       line_bit,
   output logic                       line_strobe,
   output logic [`FTX_SYM_W-1:0]      code_group,
   output logic                       code_err
);
   localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

   typedef struct packed {
      ftx_state_type              state;
      logic [DW-1:0]              div;
      logic [2:0]                 bit_cnt;
      logic [`FTX_SYM_W-1:0]      shreg;
      logic [`FTX_SYM_W-1:0]      group;
      logic [`FTX_LFSR_W-1:0]     lfsr;
      logic                       line;
      logic                       strobe;
      logic                       err;
   } ftx_coder_state_type;

   ftx_coder_state_type r;
   ftx_coder_state_type next_r;
   ftx_word_type        fifo_word;
   ftx_word_type        word;
   logic                fifo_valid;
   logic                fifo_pop;
   logic                bit_en;
   logic                load;
   logic                fb;
   logic                nrz;
   logic [`FTX_SYM_W-1:0] sym;

   // Nibble to data code-group
   function automatic logic [`FTX_SYM_W-1:0] enc4b5b(
      input logic [`FTX_NIB_W-1:0] n
   );
      case (n)
         4'h0:    enc4b5b = 5'h1E;
         4'h1:    enc4b5b = 5'h09;
         4'h2:    enc4b5b = 5'h14;
         4'h3:    enc4b5b = 5'h15;
         4'h4:    enc4b5b = 5'h0A;
         4'h5:    enc4b5b = 5'h0B;
         4'h6:    enc4b5b = 5'h0E;
         4'h7:    enc4b5b = 5'h0F;
         4'h8:    enc4b5b = 5'h12;
         4'h9:    enc4b5b = 5'h13;
         4'hA:    enc4b5b = 5'h16;
         4'hB:    enc4b5b = 5'h17;
         4'hC:    enc4b5b = 5'h1A;
         4'hD:    enc4b5b = 5'h1B;
         4'hE:    enc4b5b = 5'h1C;
         default: enc4b5b = 5'h1D;
      endcase
   endfunction : enc4b5b

   // Code-group is a data code
   function automatic logic is_data(
      input logic [`FTX_SYM_W-1:0] c
   );
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (enc4b5b(4'(i)) == c) begin
            hit = 1'b1;
         end
      end
      is_data = hit;
   endfunction : is_data

   ftx_fifo #(
      .WIDTH ($bits(ftx_word_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .resetn    (resetn),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   ({tx_en, tx_er, txd}),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_word)
   );

   // Bit-rate enable from divider
   assign bit_en   = (32'(r.div) == BIT_DIV - 1);
   assign load     = bit_en && (r.bit_cnt == `FTX_LAST_BIT); // see RL11
   assign fifo_pop = load && fifo_valid;
   assign word     = fifo_valid ? fifo_word : ftx_word_type'('0);
   assign fb       = r.lfsr[`FTX_TAP_A] ^ r.lfsr[`FTX_TAP_B]; // see RL13
   assign nrz      = scr_bypass ? r.shreg[`FTX_SYM_W-1] // see RL9
                               : r.shreg[`FTX_SYM_W-1] ^ fb; // see RL8

   assign line_bit    = r.line;
   assign line_strobe = r.strobe;
   assign code_group  = r.group;
   assign code_err    = r.err;

   always_comb begin
      next_r        = r;
      sym           = `FTX_CG_IDLE;
      next_r.strobe = 1'b0;
      next_r.err    = 1'b0;
      if (bit_en) begin
         next_r.div = '0;
      end else begin
         next_r.div = r.div + 1'b1;
      end
      if (bit_en) begin
         next_r.lfsr   = {r.lfsr[`FTX_LFSR_W-2:0], fb}; // see RL8
         next_r.line   = r.line ^ nrz; // see RL10
         next_r.strobe = 1'b1;
         next_r.shreg  = {r.shreg[`FTX_SYM_W-2:0], 1'b0};
         next_r.bit_cnt = r.bit_cnt + 3'h1;
      end
      if (load) begin
         case (r.state) // see RL12
            ftx_st_idle: begin
               if (word.en) begin
                  sym          = `FTX_CG_J; // see RL2
                  next_r.state = ftx_st_k;
               end else if (word.er && word.nib == `FTX_LPI_NIB) begin
                  sym = `FTX_CG_LPI; // see RL6
               end else begin
                  sym = `FTX_CG_IDLE; // see RL5
               end
            end
            ftx_st_k: begin
               sym          = `FTX_CG_K; // see RL2
               next_r.state = ftx_st_data;
            end
            ftx_st_data: begin
               if (!word.en) begin
                  sym          = `FTX_CG_T; // see RL4
                  next_r.state = ftx_st_r;
               end else if (word.er) begin
                  sym = `FTX_CG_HALT;
               end else begin
                  sym = enc4b5b(word.nib); // see RL1 RL3
               end
               next_r.err = word.en && !is_data(sym); // see RL7
            end
            ftx_st_r: begin
               sym          = `FTX_CG_R; // see RL4
               next_r.state = ftx_st_idle;
            end
            default: begin
               sym          = `FTX_CG_IDLE;
               next_r.state = ftx_st_idle;
            end
         endcase
         next_r.shreg   = sym;
         next_r.group   = sym;
         next_r.bit_cnt = 3'h0;
      end
      if (next_r.lfsr == '0) begin
         next_r.lfsr = `FTX_LFSR_SEED; // see RL13
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         r.state   <= ftx_st_idle;
         r.div     <= '0;
         r.bit_cnt <= 3'h0;
         r.shreg   <= `FTX_CG_IDLE;
         r.group   <= `FTX_CG_IDLE;
         r.lfsr    <= `FTX_LFSR_SEED;
         r.line    <= 1'b0;
         r.strobe  <= 1'b0;
         r.err     <= 1'b0;
      end else begin
         r <= next_r;
      end
   end
endmodule : ftx_coder

`default_nettype wire

// *** include/ftx_defs.svh ***
`ifndef FTX_DEFS_SVH
`define FTX_DEFS_SVH

// Nibble, code-group and scrambler widths
`define FTX_NIB_W      4
`define FTX_SYM_W      5
`define FTX_LFSR_W     11

// Control code-groups and LPI nibble
`define FTX_CG_IDLE    5'h1F
`define FTX_CG_J       5'h18
`define FTX_CG_K       5'h11
`define FTX_CG_T       5'h0D
`define FTX_CG_R       5'h07
`define FTX_CG_HALT    5'h04
`define FTX_CG_LPI     5'h00
`define FTX_LPI_NIB    4'h1

// Scrambler taps and seed, x^11 + x^9 + 1
`define FTX_TAP_A      10
`define FTX_TAP_B      8
`define FTX_LFSR_SEED  11'h7FF

// Line timing
`define FTX_LINE_MBPS  125
`define FTX_CLK_MHZ    40
`define FTX_BIT_DIV    1
`define FTX_LAST_BIT   3'h4

`endif

// *** include/ftx_pkg.sv ***
`include "ftx_defs.svh"

package ftx_pkg;

   typedef enum logic [1:0] {
      ftx_st_idle = 2'h0,
      ftx_st_k    = 2'h1,
      ftx_st_data = 2'h3,
      ftx_st_r    = 2'h2
   } ftx_state_type;

   typedef struct packed {
      logic                      en;
      logic                      er;
      logic [`FTX_NIB_W-1:0]     nib;
   } ftx_word_type;

endpackage : ftx_pkg

// *** verilog/ftx_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none

module ftx_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } ftx_fifo_state_type;

   ftx_fifo_state_type r;
   ftx_fifo_state_type next_r;
   logic [WIDTH-1:0]   mem [DEPTH];
   logic               push;
   logic               pop;

   // Full when pointers differ only in the wrap bit
   assign in_ready  = (r.wr[AW] == r.rd[AW]) || (r.wr[AW-1:0] != r.rd[AW-1:0]);
   assign out_valid = (r.wr != r.rd);
   assign out_data  = mem[r.rd[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_r = r;
      if (push) begin
         next_r.wr = r.wr + 1'b1;
      end
      if (pop) begin
         next_r.rd = r.rd + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[r.wr[AW-1:0]] <= in_data;
      end
   end
endmodule : ftx_fifo

`default_nettype wire

// *** verif/ftx_coder_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module ftx_coder_chk (
   input wire logic       clock,
   input wire logic       resetn,
   input wire logic       scr_bypass,
   input wire logic       line_bit,
   input wire logic       line_strobe,
   input wire logic [4:0] code_group,
   input wire logic       code_err
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_bit_strobe: assert property ($past(resetn) |-> line_strobe)
      else $error("strobe gap");
   a_group_hold: assert property ($changed(code_group) |=> $stable(code_group)[*4])
      else $error("group too short");
   a_idle_nrzi: assert property (
      (scr_bypass && code_group == 5'h1F)[*6] |-> $changed(line_bit)) else $error("no toggle");
   a_start_pair: assert property (
      $changed(code_group) && code_group == 5'h18 |-> ##5 code_group == 5'h11) else $error("no K");
   a_k_after_j: assert property (
      $changed(code_group) && code_group == 5'h11 |-> $past(code_group, 5) == 5'h18)
      else $error("K without J");
   a_end_pair: assert property (
      $changed(code_group) && code_group == 5'h0D |-> ##5 code_group == 5'h07) else $error("no R");
   a_lpi_idle: assert property (
      $changed(code_group) && code_group == 5'h00 |-> $past(code_group, 5) inside {5'h1F, 5'h07})
      else $error("LPI in frame");
   a_err_pulse: assert property (code_err |=> !code_err)
      else $error("error flag held");
endmodule : ftx_coder_chk
`default_nettype wire

// *** verif/ftx_mac_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ftx_mac_model (
   input  wire logic clock,
   input  wire logic tx_ready,
   output logic      tx_valid,
   output logic      tx_en,
   output logic      tx_er,
   output logic [3:0] txd
);
   initial begin
      tx_valid = 1'b0;
      tx_en = 1'b0;
      tx_er = 1'b0;
      txd = 4'hA;
   end
   // Offer a word and hold it until taken
   task automatic send(input logic en, input logic er, input logic [3:0] nib);
      int n;
      @(negedge clock);
      tx_valid = 1'b1;
      tx_en = en;
      tx_er = er;
      txd = nib;
      n = 0;
      // Ready is judged where it has settled, then the word is taken on the next rising edge
      while (tx_ready !== 1'b1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      if (n >= 200) test_ftx_coder.hang();
      else @(posedge clock);
   endtask : send
   // Released fields stop showing the last word
   task automatic idle_bus();
      @(negedge clock);
      tx_valid = 1'b0;
      tx_en = ~tx_en;
      tx_er = ~tx_er;
      txd = ~txd;
   endtask : idle_bus
endmodule : ftx_mac_model
`default_nettype wire

// *** verif/test_ftx_coder.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_ftx_coder;
   logic clock, resetn, scr_bypass, tx_valid, tx_ready, tx_en, tx_er;
   logic line_bit, line_strobe, code_err, last_bit;
   logic [3:0] txd;
   logic [4:0] code_group, last_cg;
   logic [4:0] seen[$];
   int err_count, num_checks, n_err, flips, rdy_low;
   localparam logic [4:0] enc_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
      5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   ftx_coder #(.BIT_DIV(1), .FIFO_DEPTH(8)) ftx_coder_i (.clock(clock), .resetn(resetn),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
      .scr_bypass(scr_bypass), .line_bit(line_bit), .line_strobe(line_strobe),
      .code_group(code_group), .code_err(code_err));
   ftx_mac_model ftx_mac_model_i (.clock(clock), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_en(tx_en), .tx_er(tx_er), .txd(txd));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(negedge clock) begin
      if (resetn === 1'b1 && code_group !== last_cg) seen.push_back(code_group);
      if (resetn === 1'b1 && code_err === 1'b1) n_err++;
      if (resetn === 1'b1 && tx_ready === 1'b0) rdy_low++;
      if (line_strobe === 1'b1 && line_bit !== last_bit) flips++;
      last_cg = code_group;
      last_bit = line_bit;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic hang();
      err_count++;
      close_out();
   endtask : hang
   task automatic wait_for(input int n);
      for (int i = 0; i < 3000 && seen.size() < n; i++) @(posedge clock);
      if (seen.size() < n) hang();
   endtask : wait_for
   task automatic frame_data();
      logic [4:0] exp[$];
      seen = {};
      n_err = 0;
      rdy_low = 0;
      exp = {5'h18, 5'h11};
      for (int i = 0; i < 16; i++) exp.push_back(enc_tab[i]);
      exp = {exp, 5'h0D, 5'h07, 5'h1F};
      for (int i = 0; i < 18; i++) ftx_mac_model_i.send(1'b1, 1'b0, i < 2 ? 4'h5 : 4'(i - 2));
      ftx_mac_model_i.idle_bus();
      wait_for(21);
      for (int i = 0; i < 21; i++) check(8'(seen[i]), 8'(exp[i]));
      check(8'(n_err), 8'h00);
      check(8'(rdy_low > 0), 8'h01);
   endtask : frame_data
   task automatic frame_err_lpi();
      logic [4:0] exp[$];
      seen = {};
      n_err = 0;
      exp = {5'h18, 5'h11, 5'h04, 5'h0D, 5'h07, 5'h1F, 5'h00, 5'h1F};
      ftx_mac_model_i.send(1'b1, 1'b0, 4'h5);
      ftx_mac_model_i.send(1'b1, 1'b0, 4'h5);
      ftx_mac_model_i.send(1'b1, 1'b1, 4'h3);
      ftx_mac_model_i.idle_bus();
      wait_for(6);
      repeat (3) ftx_mac_model_i.send(1'b0, 1'b1, 4'h1);
      ftx_mac_model_i.idle_bus();
      wait_for(8);
      for (int i = 0; i < 8; i++) check(8'(seen[i]), 8'(exp[i]));
      check(8'(n_err), 8'h01);
   endtask : frame_err_lpi
   task automatic scramble();
      @(negedge clock);
      scr_bypass = 1'b1;
      repeat (10) @(posedge clock);
      flips = 0;
      repeat (64) @(posedge clock);
      check(8'(flips), 8'd64);
      @(negedge clock);
      scr_bypass = 1'b0;
      repeat (10) @(posedge clock);
      flips = 0;
      repeat (64) @(posedge clock);
      check(8'(flips inside {[8:56]}), 8'h01);
   endtask : scramble
   initial begin
      resetn = 1'b0;
      scr_bypass = 1'b0;
      last_cg = 5'h1F;
      last_bit = 1'b0;
      repeat (16) @(posedge clock);
      @(negedge clock);
      resetn = 1'b1;
      scramble();
      frame_data();
      frame_err_lpi();
      close_out();
   end
endmodule : test_ftx_coder
bind ftx_coder ftx_coder_chk ftx_coder_chk_i (.clock(clock), .resetn(resetn),
   .scr_bypass(scr_bypass), .line_bit(line_bit), .line_strobe(line_strobe),
   .code_group(code_group), .code_err(code_err));
`default_nettype wire
